/* File: common/protect_pkg.sv */
/*
 Constants, types and timing for the drive protection monitor.
 Assumes a 40 MHz core clock; currents and settings arrive as plain numbers.
*/
package protect_pkg;
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned TICK_HZ         = 10;
   localparam int unsigned TICK_CYCLES     = CLK_HZ / TICK_HZ;
   localparam int          CUR_W           = 16;
   localparam int          TIME_W          = 12;
   localparam int          FUNC_W          = 5;
   localparam int          NUM_INPUTS      = 8;
   localparam int          PCT_W           = 8;
   localparam int          AN_W            = 12;
   localparam logic [7:0]  WARN_TIME_DEF   = 8'h0A;
   localparam logic [7:0]  TRIP_TIME_DEF   = 8'h3C;
   localparam logic [7:0]  WAIT_TIME_DEF   = 8'h0A;
   localparam logic [7:0]  STALL_LEVEL_DEF = 8'h96;
   localparam int          PCT_DIV         = 100;
   localparam int          TENTHS_PER_S    = 10;
   localparam logic [4:0]  FN_OVERLOAD     = 5'h05;
   localparam logic [4:0]  FN_INV_OVERLOAD = 5'h06;
   localparam logic [4:0]  FN_STALL        = 5'h07;
   localparam logic [4:0]  FN_CMD_LOSS     = 5'h0B;
   localparam logic [4:0]  FN_EXT_TRIP_NO  = 5'h12;
   localparam logic [4:0]  FN_EXT_TRIP_NC  = 5'h13;
   localparam int          MASK_ACC        = 0;
   localparam int          MASK_CONST      = 1;
   localparam int          MASK_DEC        = 2;
   localparam logic [1:0]  PL_OFF          = 2'h0;
   localparam logic [1:0]  PL_OUT          = 2'h1;
   localparam logic [1:0]  PL_IN           = 2'h2;
   localparam logic [1:0]  PL_BOTH         = 2'h3;
   localparam logic [1:0]  AL_OFF          = 2'h0;
   localparam logic [1:0]  AL_HALF         = 2'h1;
   localparam logic [1:0]  AL_MIN          = 2'h2;
   localparam logic [1:0]  ACT_CONTINUE    = 2'h0;
   localparam logic [1:0]  ACT_COAST       = 2'h1;
   localparam logic [1:0]  ACT_DECEL       = 2'h2;

   typedef enum logic [1:0] {
      PH_STOP  = 2'b00,
      PH_ACC   = 2'b01,
      PH_CONST = 2'b11,
      PH_DEC   = 2'b10
   } ramp_phase_t;

   typedef enum logic [1:0] {
      LS_OK    = 2'b00,
      LS_WAIT  = 2'b01,
      LS_ACTED = 2'b11
   } loss_state_t;

   typedef struct packed {
      logic [7:0] warn_level;
      logic [7:0] warn_time;
      logic       trip_enable;
      logic [7:0] trip_level;
      logic [7:0] trip_time;
      logic [2:0] stall_mask;
      logic [7:0] stall_level;
   } overload_cfg_t;

   typedef struct packed {
      logic [1:0]  criterion;
      logic        combined_ref;
      logic        comm_ref;
      logic [1:0]  action;
      logic [10:0] wait_time;
      logic [11:0] volt_min;
      logic [11:0] curr_min;
   } loss_cfg_t;

   typedef struct packed {
      logic overload_warn;
      logic inv_overload;
      logic stall;
      logic cmd_loss;
   } status_t;
endpackage : protect_pkg

/* File: hw/persist_timer.sv */
/*
 Persistence timer: flags once a condition has held for a set count of ticks.
 Assumes tick is a one-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module persist_timer #(
   parameter int W = 12
) (
   input  wire logic         core_clk,  // System clock
   input  wire logic         rstn,      // Synchronous reset, active low
   input  wire logic         tick,      // Time base pulse
   input  wire logic         cond,      // Condition being timed
   input  wire logic [W-1:0] limit,     // Ticks the condition must hold
   output logic              expired    // Condition held long enough
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic         expired_r;
   logic         expired_nxt;

   always_comb begin
      count_nxt   = count_r;
      expired_nxt = expired_r;
      if (!cond) begin
         count_nxt   = '0;
         expired_nxt = 1'b0;
      end else if (count_r >= limit) begin
         expired_nxt = 1'b1;
      end else if (tick) begin
         count_nxt = count_r + W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         count_r   <= '0;
         expired_r <= 1'b0;
      end else begin
         count_r   <= count_nxt;
         expired_r <= expired_nxt;
      end
   end

   assign expired = expired_r;
endmodule : persist_timer
`default_nettype wire

/* File: hw/drive_protection_monitor.sv */
/*
 Drive protection monitor: overload warning and trip, stall prevention,
 phase loss, external trips, inverter overload and reference loss.
 Assumes currents in amps scaled alike, settings held stable by the
 parameter store, and contact inputs straight from the terminal pins.
*/
// Behaviour
// - Warn when current exceeds warn level for time
// - Collector output shows warning at code 5
// - Trip output off after sustained overcurrent
// - Accel stall: decelerate above stall level
// - Constant run stall: reduce speed above level
// - Decel stall: hold decel on high DC link
// - Stall level is percent of rated current
// - Stall status at code 7: overcurrent regardless of mask, DC link hold only with decel mask bit
// - Ramps stretch while accel or decel stall prevention acts, not constant run stall
// - Phase loss select 0 off,1 out,2 in,3 both
// - Output phase loss shuts output off
// - Input phase loss or capacitor due blocks output
// - Eight inputs each selectable as external trip
// - Code 18 trips on closed contact
// - Code 19 trips on open contact
// - Inverter overload signalled at code 6
// - Analog loss criterion off, half minimum, minimum
// - Combined reference lost if either input low
// - After wait apply continue, coast or decelerate
// - Reference loss shown at code 11
// - Loss detection covers communication references
`timescale 1ns/1ps
`default_nettype none
module drive_protection_monitor
   import protect_pkg::*;
#(
   parameter int TICK_DIV = TICK_CYCLES
) (
   input  wire logic                    core_clk,               // 40 MHz clock
   input  wire logic                    rstn,                   // Sync reset, active low
   input  wire logic [CUR_W-1:0]        output_current,         // Measured current
   input  wire logic [CUR_W-1:0]        rated_current_setting,  // Motor rated current
   input  wire logic [CUR_W-1:0]        inverter_rated_current, // Inverter rating
   input  wire overload_cfg_t           ovl_cfg,                // Overload and stall setup
   input  wire ramp_phase_t             ramp_phase,             // Present ramp phase
   input  wire logic                    dc_link_high,           // DC link above limit
   input  wire logic [1:0]              phase_loss_select,      // Phase loss mode
   input  wire logic [2:0]              out_phase_ok,           // U V W present
   input  wire logic                    in_phase_lost,          // Input phase missing
   input  wire logic                    cap_replace_due,        // Capacitor worn out
   input  wire logic [NUM_INPUTS-1:0]   digital_inputs,         // Contact pins, 1 closed
   input  wire logic [NUM_INPUTS*FUNC_W-1:0] input_functions,   // Function per input
   input  wire logic [FUNC_W-1:0]       collector_out_function, // Collector select
   input  wire logic [FUNC_W-1:0]       relay_function,         // Relay select
   input  wire loss_cfg_t               loss_cfg,               // Reference loss setup
   input  wire logic [AN_W-1:0]         analog_voltage_input,   // Voltage reference
   input  wire logic [AN_W-1:0]         analog_current_input,   // Current reference
   input  wire logic                    comm_ref_lost,          // Option link silent
   output logic                         output_off,             // Gate output off
   output logic                         fault,                  // Fault shown
   output logic                         stall_decel,            // Start or force decel
   output logic                         stall_hold_decel,       // Pause deceleration
   output logic                         ramp_stretch,           // Ramp may run long
   output logic                         hold_frequency,         // Keep last frequency
   output logic                         loss_decel_stop,        // Decelerate to stop
   output status_t                      status,                 // Status flags
   output logic                         open_collector_output,  // Collector terminal
   output logic                         relay_contacts          // Relay coil
);
   localparam int PROD_W = CUR_W + PCT_W;

   // Time base of 100 ms
   logic [31:0] tick_cnt_r;
   logic [31:0] tick_cnt_nxt;
   logic        tick_r;
   logic        tick_nxt;

   always_comb begin
      tick_nxt     = 1'b0;
      tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
      if (tick_cnt_r >= 32'(TICK_DIV - 1)) begin
         tick_cnt_nxt = '0;
         tick_nxt     = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         tick_cnt_r <= '0;
         tick_r     <= 1'b0;
      end else begin
         tick_cnt_r <= tick_cnt_nxt;
         tick_r     <= tick_nxt;
      end
   end

   // Contact synchronisers: three stages, change once stages two and three agree
   logic [NUM_INPUTS-1:0] din_s1_r;
   logic [NUM_INPUTS-1:0] din_s2_r;
   logic [NUM_INPUTS-1:0] din_s3_r;
   logic [NUM_INPUTS-1:0] din_r;
   logic [NUM_INPUTS-1:0] din_nxt;

   always_comb begin
      din_nxt = din_r;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (din_s2_r[i] == din_s3_r[i]) begin
            din_nxt[i] = din_s3_r[i];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         din_s1_r <= '0;
         din_s2_r <= '0;
         din_s3_r <= '0;
         din_r    <= '0;
      end else begin
         din_s1_r <= digital_inputs;
         din_s2_r <= din_s1_r;
         din_s3_r <= din_s2_r;
         din_r    <= din_nxt;
      end
   end

   // Current levels as percent of rated current; inverter overload compares plain current with inverter rating
   logic [PROD_W-1:0] cur_scaled;
   logic [PROD_W-1:0] warn_lim;
   logic [PROD_W-1:0] trip_lim;
   logic [PROD_W-1:0] stall_lim;
   logic              over_warn;
   logic              over_trip;
   logic              over_stall;
   logic              over_inverter;

   always_comb begin
      cur_scaled = PROD_W'(output_current) * PROD_W'(PCT_DIV);
      warn_lim   = PROD_W'(rated_current_setting) * PROD_W'(ovl_cfg.warn_level);
      trip_lim   = PROD_W'(rated_current_setting) * PROD_W'(ovl_cfg.trip_level);
      stall_lim  = PROD_W'(rated_current_setting) * PROD_W'(ovl_cfg.stall_level);
      over_warn     = cur_scaled > warn_lim;
      over_trip     = cur_scaled > trip_lim;
      over_stall    = cur_scaled > stall_lim;
      over_inverter = output_current > inverter_rated_current;
   end

   logic warn_expired;
   logic trip_expired;

   persist_timer #(.W(TIME_W)) u_warn_timer (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tick     (tick_r),
      .cond     (over_warn),
      .limit    (TIME_W'(ovl_cfg.warn_time) * TIME_W'(TENTHS_PER_S)),
      .expired  (warn_expired)
   );

   persist_timer #(.W(TIME_W)) u_trip_timer (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tick     (tick_r),
      .cond     (over_trip & ovl_cfg.trip_enable),
      .limit    (TIME_W'(ovl_cfg.trip_time) * TIME_W'(TENTHS_PER_S)),
      .expired  (trip_expired)
   );

   // Reference loss detection
   logic ref_low;
   logic loss_seen;
   logic loss_waited;

   always_comb begin
      ref_low = 1'b0;
      if (loss_cfg.combined_ref) begin
         if (loss_cfg.criterion != AL_OFF) begin
            ref_low = (analog_voltage_input < loss_cfg.volt_min) |
                      (analog_current_input < loss_cfg.curr_min);
         end
      end else if (loss_cfg.criterion == AL_HALF) begin
         ref_low = analog_voltage_input < (loss_cfg.volt_min >> 1);
      end else if (loss_cfg.criterion == AL_MIN) begin
         ref_low = analog_voltage_input < loss_cfg.volt_min;
      end
      loss_seen = loss_cfg.comm_ref ? comm_ref_lost : ref_low;
   end

   persist_timer #(.W(TIME_W)) u_loss_timer (
      .core_clk (core_clk),
      .rstn     (rstn),
      .tick     (tick_r),
      .cond     (loss_seen),
      .limit    (TIME_W'(loss_cfg.wait_time)),
      .expired  (loss_waited)
   );

   loss_state_t loss_state_r;
   loss_state_t loss_state_nxt;

   always_comb begin
      loss_state_nxt = loss_state_r;
      case (loss_state_r)
         LS_OK: begin
            if (loss_seen) begin
               loss_state_nxt = LS_WAIT;
            end
         end
         LS_WAIT: begin
            if (!loss_seen) begin
               loss_state_nxt = LS_OK;
            end else if (loss_waited) begin
               loss_state_nxt = LS_ACTED;
            end
         end
         LS_ACTED: begin
            if (!loss_seen) begin
               loss_state_nxt = LS_OK;
            end
         end
         default: loss_state_nxt = LS_OK;
      endcase
   end

   // External trips, phase loss and output decisions
   logic ext_trip;
   logic phase_trip;
   logic stall_act;
   logic stall_hold;
   logic stall_any;
   logic loss_acted;
   status_t status_nxt;

   always_comb begin
      ext_trip = 1'b0;
      for (int i = 0; i < NUM_INPUTS; i++) begin
         if (input_functions[i*FUNC_W +: FUNC_W] == FN_EXT_TRIP_NO && din_r[i]) begin
            ext_trip = 1'b1;
         end
         if (input_functions[i*FUNC_W +: FUNC_W] == FN_EXT_TRIP_NC && !din_r[i]) begin
            ext_trip = 1'b1;
         end
      end
      phase_trip = 1'b0;
      if (phase_loss_select == PL_OUT || phase_loss_select == PL_BOTH) begin
         phase_trip = phase_trip | ~&out_phase_ok;
      end
      if (phase_loss_select == PL_IN || phase_loss_select == PL_BOTH) begin
         phase_trip = phase_trip | in_phase_lost | cap_replace_due;
      end
      stall_act  = over_stall &
                   ((ramp_phase == PH_ACC   && ovl_cfg.stall_mask[MASK_ACC]) |
                    (ramp_phase == PH_CONST && ovl_cfg.stall_mask[MASK_CONST]));
      stall_hold = dc_link_high && ramp_phase == PH_DEC &&
                   ovl_cfg.stall_mask[MASK_DEC];
      stall_any  = over_stall | stall_hold;
      loss_acted = loss_state_r == LS_ACTED;
      status_nxt.overload_warn = warn_expired;
      status_nxt.inv_overload  = over_inverter;
      status_nxt.stall         = stall_any;
      status_nxt.cmd_loss      = loss_state_r != LS_OK;
   end

   logic    output_off_r;
   logic    fault_r;
   logic    stall_decel_r;
   logic    stall_hold_r;
   logic    stretch_r;
   logic    hold_freq_r;
   logic    loss_stop_r;
   status_t status_r;
   logic    collector_r;
   logic    relay_r;

   function automatic logic route_out(input logic [FUNC_W-1:0] fn, input status_t st);
      logic res;
      res = 1'b0;
      if (fn == FN_OVERLOAD) begin
         res = st.overload_warn;
      end else if (fn == FN_INV_OVERLOAD) begin
         res = st.inv_overload;
      end else if (fn == FN_STALL) begin
         res = st.stall;
      end else if (fn == FN_CMD_LOSS) begin
         res = st.cmd_loss;
      end
      return res;
   endfunction : route_out

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         loss_state_r  <= LS_OK;
         output_off_r  <= 1'b0;
         fault_r       <= 1'b0;
         stall_decel_r <= 1'b0;
         stall_hold_r  <= 1'b0;
         stretch_r     <= 1'b0;
         hold_freq_r   <= 1'b0;
         loss_stop_r   <= 1'b0;
         status_r      <= '0;
         collector_r   <= 1'b0;
         relay_r       <= 1'b0;
      end else begin
         loss_state_r  <= loss_state_nxt;
         output_off_r  <= trip_expired | phase_trip | ext_trip |
                          (loss_acted && loss_cfg.action == ACT_COAST);
         fault_r       <= trip_expired | phase_trip | ext_trip;
         stall_decel_r <= stall_act;
         stall_hold_r  <= stall_hold;
         stretch_r     <= (stall_act && ramp_phase == PH_ACC) | stall_hold;
         hold_freq_r   <= loss_acted && loss_cfg.action == ACT_CONTINUE;
         loss_stop_r   <= loss_acted && loss_cfg.action == ACT_DECEL;
         status_r      <= status_nxt;
         collector_r   <= route_out(collector_out_function, status_nxt);
         relay_r       <= route_out(relay_function, status_nxt);
      end
   end

   assign output_off            = output_off_r;
   assign fault                 = fault_r;
   assign stall_decel           = stall_decel_r;
   assign stall_hold_decel      = stall_hold_r;
   assign ramp_stretch          = stretch_r;
   assign hold_frequency        = hold_freq_r;
   assign loss_decel_stop       = loss_stop_r;
   assign status                = status_r;
   assign open_collector_output = collector_r;
   assign relay_contacts        = relay_r;
endmodule : drive_protection_monitor
`default_nettype wire

/* File: test/drive_side_model.sv */
/* Sensing side model: sensed current and contact pins.
   Assumes set values change at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module drive_side_model
   import protect_pkg::*;
(
   input  wire logic [CUR_W-1:0]      cur_set,        // Current to report
   input  wire logic [NUM_INPUTS-1:0] pins_set,       // Contacts, 1 closed
   input  wire logic                  core_clk,       // Core clock
   output logic      [CUR_W-1:0]      output_current, // Sensed current
   output logic      [NUM_INPUTS-1:0] digital_inputs  // Terminal pins
);
   // Settle on the falling edge
   always @(negedge core_clk) begin
      output_current <= cur_set;
      digital_inputs <= pins_set;
   end
endmodule : drive_side_model
`default_nettype wire

/* File: test/drive_protection_monitor_asserts.sv */
/* Port checks of the protection monitor.
   Assumes synchronous active-low rstn. */
`timescale 1ns/1ps
`default_nettype none
module protect_asserts
   import protect_pkg::*;
(
   input wire logic                          core_clk,
   input wire logic                          rstn,
   input wire logic [CUR_W-1:0]              output_current,
   input wire logic [CUR_W-1:0]              rated_current_setting,
   input wire logic [CUR_W-1:0]              inverter_rated_current,
   input wire overload_cfg_t                 ovl_cfg,
   input wire ramp_phase_t                   ramp_phase,
   input wire logic                          dc_link_high,
   input wire logic [1:0]                    phase_loss_select,
   input wire logic [2:0]                    out_phase_ok,
   input wire logic                          in_phase_lost,
   input wire logic [NUM_INPUTS-1:0]         digital_inputs,
   input wire logic [NUM_INPUTS*FUNC_W-1:0]  input_functions,
   input wire logic [FUNC_W-1:0]             collector_out_function,
   input wire logic [FUNC_W-1:0]             relay_function,
   input wire logic                          output_off,
   input wire logic                          fault,
   input wire logic                          stall_decel,
   input wire logic                          stall_hold_decel,
   input wire status_t                       status,
   input wire logic                          open_collector_output,
   input wire logic                          relay_contacts
);
   wire logic over_stall = output_current * PCT_DIV > ovl_cfg.stall_level * rated_current_setting;
   wire logic over_trip = output_current * PCT_DIV > ovl_cfg.trip_level * rated_current_setting;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   property p_warn_oc;
      (collector_out_function == FN_OVERLOAD && status.overload_warn) [*3] |-> open_collector_output;
   endproperty
   a_warn_oc: assert property (p_warn_oc) else $error("no warn out");
   property p_trip;
      (ovl_cfg.trip_enable && ovl_cfg.trip_time == 8'h00 && over_trip) [*4] |-> output_off && fault;
   endproperty
   a_trip: assert property (p_trip) else $error("no trip");
   property p_acc;
      (ramp_phase == PH_ACC && ovl_cfg.stall_mask[MASK_ACC] && over_stall) [*3] |-> stall_decel;
   endproperty
   a_acc: assert property (p_acc) else $error("accel stall missing");
   property p_const;
      (ramp_phase == PH_CONST && ovl_cfg.stall_mask[MASK_CONST] && over_stall) [*3] |-> stall_decel;
   endproperty
   a_const: assert property (p_const) else $error("no const stall");
   property p_dec;
      (ramp_phase == PH_DEC && ovl_cfg.stall_mask[MASK_DEC] && dc_link_high) [*3] |-> stall_hold_decel;
   endproperty
   a_dec: assert property (p_dec) else $error("decel hold missing");
   property p_stall_relay;
      (relay_function == FN_STALL && over_stall) [*3] |-> relay_contacts;
   endproperty
   a_stall_relay: assert property (p_stall_relay) else $error("stall relay missing");
   property p_out_loss;
      (phase_loss_select[0] && out_phase_ok != 3'h7) [*3] |-> output_off;
   endproperty
   a_out_loss: assert property (p_out_loss) else $error("no out loss trip");
   property p_in_loss;
      (phase_loss_select[1] && in_phase_lost) [*3] |-> output_off;
   endproperty
   a_in_loss: assert property (p_in_loss) else $error("no in loss trip");
   property p_ext_no;
      (input_functions[34:30] == FN_EXT_TRIP_NO && digital_inputs[6]) [*8] |-> fault && output_off;
   endproperty
   a_ext_no: assert property (p_ext_no) else $error("no ext trip");
   property p_inv;
      (output_current > inverter_rated_current) [*3] |-> status.inv_overload;
   endproperty
   a_inv: assert property (p_inv) else $error("no inv overload");
endmodule : protect_asserts
bind drive_protection_monitor protect_asserts u_chk (.*);
`default_nettype wire

/* File: test/drive_protection_monitor_test.sv */
/* Bench for the protection monitor.
   Assumes rated current 100: percents read as current. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module drive_protection_monitor_test;
   import protect_pkg::*;
   logic                         core_clk, rstn, dc_link_high, in_phase_lost, cap_replace_due;
   logic                         comm_ref_lost, output_off, fault, stall_decel, stall_hold_decel;
   logic                         ramp_stretch, hold_frequency, loss_decel_stop;
   logic                         open_collector_output, relay_contacts;
   logic [CUR_W-1:0]             output_current, rated_current_setting, inverter_rated_current;
   logic [CUR_W-1:0]             cur_set;
   logic [NUM_INPUTS-1:0]        digital_inputs, pins_set;
   logic [NUM_INPUTS*FUNC_W-1:0] input_functions;
   logic [FUNC_W-1:0]            collector_out_function, relay_function;
   logic [1:0]                   phase_loss_select;
   logic [2:0]                   out_phase_ok;
   logic [AN_W-1:0]              analog_voltage_input, analog_current_input;
   overload_cfg_t                ovl_cfg;
   loss_cfg_t                    loss_cfg;
   ramp_phase_t                  ramp_phase;
   status_t                      status;
   int                           num_errors = 0, checks = 0, cyc = 0;

   drive_side_model partner (.core_clk(core_clk), .cur_set(cur_set), .pins_set(pins_set),
      .output_current(output_current), .digital_inputs(digital_inputs));
   drive_protection_monitor #(.TICK_DIV(10)) dut (.*);

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         stop_test();
      end
   end

   task stop_test();
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test

   task wt(int n);
      repeat (n) @(negedge core_clk);
   endtask : wt

   task t_warn();
      ovl_cfg.warn_level = 8'h78;
      ovl_cfg.warn_time = 8'h00;
      collector_out_function = FN_OVERLOAD;
      cur_set <= 16'h0079;
      wt(6);
      `CHK("warn", 1'b1, status.overload_warn)
      `CHK("collector", 1'b1, open_collector_output)
      cur_set <= 16'h0078;
      wt(6);
      `CHK("warn_at_level", 1'b0, status.overload_warn)
   endtask : t_warn

   task t_trip();
      ovl_cfg.trip_enable = 1'b1;
      ovl_cfg.trip_level = 8'h96;
      ovl_cfg.trip_time = 8'h01;
      cur_set <= 16'h0097;
      wt(80);
      `CHK("trip_early", 1'b0, output_off)
      cur_set <= 16'h0096;
      wt(3);
      cur_set <= 16'h0097;
      wt(80);
      `CHK("trip_restart", 1'b0, output_off)
      wt(50);
      `CHK("trip_off", 1'b1, output_off)
      `CHK("trip_fault", 1'b1, fault)
      ovl_cfg.trip_time = 8'h00;
      wt(4);
      ovl_cfg.trip_enable = 1'b0;
      wt(4);
      `CHK("trip_disabled", 1'b0, output_off)
   endtask : t_trip

   task t_stall();
      logic [2:0] m;
      logic a, c, d;
      relay_function = FN_STALL;
      dc_link_high = 1'b1;
      cur_set <= 16'h00A0;
      for (int k = 0; k < 24; k++) begin
         m = 3'(k % 8);
         a = k < 8;
         d = k >= 16;
         c = !a && !d;
         ovl_cfg.stall_mask = m;
         ramp_phase = a ? PH_ACC : (d ? PH_DEC : PH_CONST);
         wt(4);
         `CHK("stall_decel", (a && m[0]) || (c && m[1]), stall_decel)
         `CHK("hold_decel", d && m[2], stall_hold_decel)
         `CHK("stretch", (a && m[0]) || (d && m[2]), ramp_stretch)
         `CHK("stall_relay", 1'b1, relay_contacts)
      end
      ramp_phase = PH_ACC;
      rated_current_setting = 16'h00C8;
      wt(4);
      `CHK("stall_scaled", 1'b0, stall_decel)
   endtask : t_stall

   task t_phase();
      for (int s = 0; s < 4; s++) begin
         phase_loss_select = 2'(s);
         out_phase_ok = 3'h5;
         wt(4);
         `CHK("out_loss", s[0], output_off)
         out_phase_ok = 3'h7;
         in_phase_lost = 1'b1;
         wt(4);
         `CHK("in_loss", s[1], output_off)
         in_phase_lost = 1'b0;
         cap_replace_due = 1'b1;
         wt(4);
         `CHK("cap_due", s[1], output_off)
         cap_replace_due = 1'b0;
      end
      phase_loss_select = PL_OFF;
   endtask : t_phase

   task t_ext();
      input_functions[34:30] = FN_EXT_TRIP_NO;
      pins_set <= 8'h80;
      input_functions[39:35] = FN_EXT_TRIP_NC;
      wt(8);
      `CHK("ext_idle", 1'b0, fault)
      pins_set <= 8'hC0;
      wt(8);
      `CHK("ext_no", 1'b1, fault)
      `CHK("ext_no_off", 1'b1, output_off)
      pins_set <= 8'h00;
      wt(8);
      `CHK("ext_nc", 1'b1, fault)
      pins_set <= 8'h80;
      wt(8);
      `CHK("ext_clear", 1'b0, fault)
   endtask : t_ext

   task t_inv();
      collector_out_function = FN_INV_OVERLOAD;
      cur_set <= 16'h00C9;
      wt(4);
      `CHK("inv_ovl", 1'b1, open_collector_output)
      cur_set <= 16'h00C8;
      wt(4);
      `CHK("inv_ovl_at", 1'b0, open_collector_output)
   endtask : t_inv

   task t_loss();
      relay_function = FN_CMD_LOSS;
      loss_cfg = '{AL_HALF, 1'b0, 1'b0, ACT_COAST, 11'h002, 12'h064, 12'h0C8};
      analog_voltage_input = 12'h032;
      wt(6);
      `CHK("half_edge", 1'b0, relay_contacts)
      analog_voltage_input = 12'h031;
      wt(6);
      `CHK("half_loss", 1'b1, status.cmd_loss)
      `CHK("loss_relay", 1'b1, relay_contacts)
      `CHK("coast_early", 1'b0, output_off)
      wt(40);
      `CHK("coast", 1'b1, output_off)
      loss_cfg.action = ACT_DECEL;
      wt(4);
      `CHK("decel_stop", 1'b1, loss_decel_stop)
      loss_cfg.action = ACT_CONTINUE;
      wt(4);
      `CHK("continue", 1'b1, hold_frequency)
      loss_cfg.criterion = AL_MIN;
      analog_voltage_input = 12'h064;
      wt(6);
      `CHK("min_edge", 1'b0, status.cmd_loss)
      analog_voltage_input = 12'h063;
      wt(6);
      `CHK("min_loss", 1'b1, status.cmd_loss)
      loss_cfg.criterion = AL_OFF;
      analog_voltage_input = 12'h000;
      wt(6);
      `CHK("crit_off", 1'b0, status.cmd_loss)
      loss_cfg.criterion = AL_MIN;
      analog_voltage_input = 12'hFFF;
      loss_cfg.combined_ref = 1'b1;
      analog_current_input = 12'h0C7;
      wt(6);
      `CHK("combined", 1'b1, status.cmd_loss)
      loss_cfg.comm_ref = 1'b1;
      comm_ref_lost = 1'b1;
      wt(6);
      `CHK("comm_loss", 1'b1, status.cmd_loss)
      comm_ref_lost = 1'b0;
      wt(6);
      `CHK("comm_ok", 1'b0, status.cmd_loss)
   endtask : t_loss

   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      rated_current_setting = 16'h0064;
      inverter_rated_current = 16'h00C8;
      input_functions = '0;
      phase_loss_select = PL_OFF;
      out_phase_ok = 3'h7;
      ramp_phase = PH_STOP;
      ovl_cfg = '{8'h96, WARN_TIME_DEF, 1'b0, 8'hB4, TRIP_TIME_DEF, 3'h0, STALL_LEVEL_DEF};
      loss_cfg = '{AL_OFF, 1'b0, 1'b0, ACT_CONTINUE, 11'h00A, 12'h064, 12'h0C8};
      wt(4);
      rstn = 1'b1;
      wt(6);
      t_warn();
      t_trip();
      t_stall();
      t_phase();
      t_ext();
      t_inv();
      t_loss();
      stop_test();
   end
endmodule : drive_protection_monitor_test
`default_nettype wire
